// [dmra_arbiter.sv]
/*
 * Register file of the deserializer shared between the local master and the
 * remote master behind the side control channel, with a fixed-priority
 * arbiter, the strap-loaded slave address and the two handover mailboxes.
 * Assumes both request ports come from I2C slave logic on i_clk_sys that
 * holds a request until its done pulse (clock stretching meanwhile); the
 * strap and direction pins come from outside and are synchronised here.
 */
`timescale 1ns/100ps

module dmra_arbiter (
	// clock, reset, enable
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_ce,
	// strap and pass-through direction
	input wire logic [2:0] i_address_strap_pin,
	input wire logic i_pt_req_camera,
	input wire logic i_pt_req_display,
	// local master register port
	input wire dmra_pkg::dmra_req_s i_local_req,
	output logic o_local_done,
	output logic [7:0] o_local_rdata,
	// remote master register port over the side control channel
	input wire dmra_pkg::dmra_req_s i_remote_req,
	output logic o_remote_done,
	output logic [7:0] o_remote_rdata,
	// address in use and pass-through grants
	output logic [6:0] o_active_slave_address,
	output logic o_pt_camera_en,
	output logic o_pt_display_en
);
	// ==========================================================
	// strap decode
	function automatic logic [6:0] strap_decode(input logic [2:0] code);
		case (code)
			3'h0: strap_decode = dmra_pkg::STRAP_ADDR_0;
			3'h1: strap_decode = dmra_pkg::STRAP_ADDR_1;
			3'h2: strap_decode = dmra_pkg::STRAP_ADDR_2;
			3'h3: strap_decode = dmra_pkg::STRAP_ADDR_3;
			3'h4: strap_decode = dmra_pkg::STRAP_ADDR_4;
			3'h5: strap_decode = dmra_pkg::STRAP_ADDR_5;
			3'h6: strap_decode = dmra_pkg::STRAP_ADDR_6;
			default: strap_decode = dmra_pkg::STRAP_ADDR_7;
		endcase
	endfunction : strap_decode

	// ==========================================================
	// pin synchronisers
	logic [2:0] strap_s1_reg, strap_s2_reg;
	logic [1:0] dir_s1_reg, dir_s2_reg;
	// strap stages keep sampling through reset, so the code is settled
	// when it is caught at the first edge after release
	always_ff @(posedge i_clk_sys) begin
		if (i_ce) begin
			strap_s1_reg <= i_address_strap_pin;
			strap_s2_reg <= strap_s1_reg;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dir_s1_reg <= 2'h0;
			dir_s2_reg <= 2'h0;
		end else if (i_ce) begin
			dir_s1_reg <= {i_pt_req_display, i_pt_req_camera};
			dir_s2_reg <= dir_s1_reg;
		end
	end

	// ==========================================================
	// register file and arbiter state
	dmra_pkg::dmra_state_e state_reg, state_next;
	logic loaded_reg, loaded_next;
	logic [6:0] strap_addr_reg, strap_addr_next;
	logic [6:0] own_addr_reg, own_addr_next;
	logic override_reg, override_next;
	logic [7:0] mbox_a_reg, mbox_a_next;
	logic [7:0] mbox_b_reg, mbox_b_next;
	logic local_done_reg, local_done_next;
	logic remote_done_reg, remote_done_next;
	logic [7:0] local_rdata_reg, local_rdata_next;
	logic [7:0] remote_rdata_reg, remote_rdata_next;
	logic [6:0] active_reg, active_next;
	logic cam_reg, cam_next;
	logic disp_reg, disp_next;
	dmra_pkg::dmra_req_s req;
	logic [7:0] rdata;

	always_comb begin
		state_next = state_reg;
		loaded_next = 1'b1;
		strap_addr_next = strap_addr_reg;
		own_addr_next = own_addr_reg;
		override_next = override_reg;
		mbox_a_next = mbox_a_reg;
		mbox_b_next = mbox_b_reg;
		local_done_next = 1'b0;
		remote_done_next = 1'b0;
		local_rdata_next = local_rdata_reg;
		remote_rdata_next = remote_rdata_reg;
		cam_next = cam_reg;
		disp_next = disp_reg;
		req = '0;
		rdata = dmra_pkg::UNMAPPED_READ;
		// strap caught once after reset release
		if (!loaded_reg) begin
			strap_addr_next = strap_decode(strap_s2_reg);
			own_addr_next = strap_decode(strap_s2_reg);
		end
		// one grant at a time; the done pulse closes it, so a held
		// request from the loser waits (stretched) until then
		case (state_reg)
			dmra_pkg::ST_IDLE: begin
				if (i_local_req.valid && !local_done_reg) begin
					state_next = dmra_pkg::ST_LOCAL;
				end else if (i_remote_req.valid && !remote_done_reg) begin
					state_next = dmra_pkg::ST_REMOTE;
				end
			end
			dmra_pkg::ST_LOCAL: begin
				req = i_local_req;
				state_next = dmra_pkg::ST_IDLE;
			end
			dmra_pkg::ST_REMOTE: begin
				req = i_remote_req;
				state_next = dmra_pkg::ST_IDLE;
			end
			default: state_next = dmra_pkg::ST_IDLE;
		endcase
		// single access point keeps same-register accesses ordered;
		// reads have no side effect: no read-to-clear or self-clearing
		// field exists in this map
		case (req.addr)
			dmra_pkg::ADDR_SLAVE_ADDRESS_SELECT: rdata = {own_addr_reg,
				override_reg};
			dmra_pkg::ADDR_HANDOVER_MAILBOX_A: rdata = mbox_a_reg;
			dmra_pkg::ADDR_HANDOVER_MAILBOX_B: rdata = mbox_b_reg;
			default: rdata = dmra_pkg::UNMAPPED_READ;
		endcase
		if (req.valid && req.write && loaded_reg) begin
			case (req.addr)
				dmra_pkg::ADDR_SLAVE_ADDRESS_SELECT: begin
					own_addr_next = req.wdata[dmra_pkg::OWN_ADDR_MSB:
						dmra_pkg::OWN_ADDR_LSB];
					override_next = req.wdata[dmra_pkg::OVERRIDE_BIT];
				end
				dmra_pkg::ADDR_HANDOVER_MAILBOX_A: mbox_a_next = req.wdata;
				dmra_pkg::ADDR_HANDOVER_MAILBOX_B: mbox_b_next = req.wdata;
				default: ;
			endcase
		end
		if (state_reg == dmra_pkg::ST_LOCAL) begin
			local_done_next = 1'b1;
			local_rdata_next = req.write ? local_rdata_reg : rdata;
		end
		if (state_reg == dmra_pkg::ST_REMOTE) begin
			remote_done_next = 1'b1;
			remote_rdata_next = req.write ? remote_rdata_reg : rdata;
		end
		// pass-through direction: first claimant keeps it until released
		if (!cam_reg && !disp_reg) begin
			cam_next = dir_s2_reg[0];
			disp_next = dir_s2_reg[1] && !dir_s2_reg[0];
		end else begin
			cam_next = cam_reg && dir_s2_reg[0];
			disp_next = disp_reg && dir_s2_reg[1];
		end
		active_next = override_next ? own_addr_next : strap_addr_next;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= dmra_pkg::ST_IDLE;
			loaded_reg <= 1'b0;
			strap_addr_reg <= dmra_pkg::STRAP_ADDR_0;
			own_addr_reg <= dmra_pkg::STRAP_ADDR_0;
			override_reg <= dmra_pkg::OVERRIDE_RESET;
			mbox_a_reg <= dmra_pkg::MAILBOX_RESET;
			mbox_b_reg <= dmra_pkg::MAILBOX_RESET;
			local_done_reg <= 1'b0;
			remote_done_reg <= 1'b0;
			local_rdata_reg <= 8'h00;
			remote_rdata_reg <= 8'h00;
			active_reg <= dmra_pkg::STRAP_ADDR_0;
			cam_reg <= 1'b0;
			disp_reg <= 1'b0;
		end else if (i_ce) begin
			state_reg <= state_next;
			loaded_reg <= loaded_next;
			strap_addr_reg <= strap_addr_next;
			own_addr_reg <= own_addr_next;
			override_reg <= override_next;
			mbox_a_reg <= mbox_a_next;
			mbox_b_reg <= mbox_b_next;
			local_done_reg <= local_done_next;
			remote_done_reg <= remote_done_next;
			local_rdata_reg <= local_rdata_next;
			remote_rdata_reg <= remote_rdata_next;
			active_reg <= active_next;
			cam_reg <= cam_next;
			disp_reg <= disp_next;
		end
	end

	// ==========================================================
	// outputs
	assign o_local_done = local_done_reg;
	assign o_local_rdata = local_rdata_reg;
	assign o_remote_done = remote_done_reg;
	assign o_remote_rdata = remote_rdata_reg;
	assign o_active_slave_address = active_reg;
	assign o_pt_camera_en = cam_reg;
	assign o_pt_display_en = disp_reg;
endmodule : dmra_arbiter

// [dmra_arbiter_checker.sv]
/* Port assertions for dmra_arbiter, bound to every instance.
   Assumes i_ce held high and masters holding requests until done. */
`timescale 1ns/100ps
module dmra_arbiter_checker (
	// clock, reset, requests
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire dmra_pkg::dmra_req_s i_local_req,
	input wire dmra_pkg::dmra_req_s i_remote_req,
	input wire logic i_pt_req_camera,
	input wire logic i_pt_req_display,
	// answers
	input wire logic o_local_done,
	input wire logic o_remote_done,
	input wire logic o_pt_camera_en,
	input wire logic o_pt_display_en
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	// ==========================================================
	// register ports and pass-through direction
	property p_local_ans;
		$rose(i_local_req.valid) |-> ##[2:4] o_local_done; endproperty
	a_local_ans: assert property (p_local_ans) else $error("local late");
	property p_remote_ans;
		$rose(i_remote_req.valid) |-> ##[2:4] o_remote_done; endproperty
	a_remote_ans: assert property (p_remote_ans) else $error("remote late");
	property p_one_done; !(o_local_done && o_remote_done); endproperty
	a_one_done: assert property (p_one_done) else $error("both done");
	property p_local_cause;
		o_local_done |-> $past(i_local_req.valid) && !$past(o_local_done);
	endproperty
	a_local_cause: assert property (p_local_cause) else $error("local done");
	property p_remote_cause;
		o_remote_done |-> $past(i_remote_req.valid) && !$past(o_remote_done);
	endproperty
	a_remote_cause: assert property (p_remote_cause) else $error("remote done");
	property p_pt_excl; !(o_pt_camera_en && o_pt_display_en); endproperty
	a_pt_excl: assert property (p_pt_excl) else $error("two directions");
	property p_cam_on;
		(!i_pt_req_display && !o_pt_display_en)[*3] ##0
		$rose(i_pt_req_camera) |-> ##3 o_pt_camera_en; endproperty
	a_cam_on: assert property (p_cam_on) else $error("camera not granted");
	property p_cam_off; $fell(i_pt_req_camera) |-> ##3 !o_pt_camera_en; endproperty
	a_cam_off: assert property (p_cam_off) else $error("camera kept");
endmodule : dmra_arbiter_checker
bind dmra_arbiter dmra_arbiter_checker u_chk (.i_clk_sys, .i_rst, .i_local_req,
	.i_remote_req, .i_pt_req_camera, .i_pt_req_display, .o_local_done,
	.o_remote_done, .o_pt_camera_en, .o_pt_display_en);

// [dmra_master_model.sv]
/* Register master as seen past its slave logic: one request port.
   Assumes a one-cycle done pulse that answers each request. */
`timescale 1ns/100ps
module dmra_master_model (
	// clock and answer
	input wire logic i_clk_sys,
	input wire logic i_done,
	input wire logic [7:0] i_rdata,
	// request
	output dmra_pkg::dmra_req_s o_req
);
	// accesses whose done never came
	int n_late = 0;
	initial o_req = '0;
	// ==========================================================
	// one access at a time, released in the done cycle
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		o_req <= '{1'b1, w, a, d};
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (i_done !== 1'b1 && n < 20);
		q = (i_done === 1'b1) ? i_rdata : 8'hxx;
		if (i_done !== 1'b1) n_late++;
		// released fields show their inverse so stale values are never used
		o_req <= '{1'b0, ~w, ~a, ~d};
	endtask : access
endmodule : dmra_master_model

// [dmra_pkg.sv]
/*
 * Constants and carrier types for the dual-master register access block.
 * Assumes an 8-bit register address and 8-bit data on both access ports.
 */
package dmra_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] ADDR_SLAVE_ADDRESS_SELECT = 8'h00;
	localparam logic [7:0] ADDR_HANDOVER_MAILBOX_A = 8'h18;
	localparam logic [7:0] ADDR_HANDOVER_MAILBOX_B = 8'h19;
	// ==========================================================
	// field layout of the address register
	localparam int OWN_ADDR_MSB = 7;
	localparam int OWN_ADDR_LSB = 1;
	localparam int OVERRIDE_BIT = 0;
	// ==========================================================
	// reset values and the unmapped read value
	localparam logic [7:0] MAILBOX_RESET = 8'h00;
	localparam logic OVERRIDE_RESET = 1'b0;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
	// ==========================================================
	// strap decode: eight levels select eight slave addresses
	localparam int STRAP_W = 3;
	localparam logic [6:0] STRAP_ADDR_0 = 7'h2c;
	localparam logic [6:0] STRAP_ADDR_1 = 7'h2e;
	localparam logic [6:0] STRAP_ADDR_2 = 7'h30;
	localparam logic [6:0] STRAP_ADDR_3 = 7'h32;
	localparam logic [6:0] STRAP_ADDR_4 = 7'h34;
	localparam logic [6:0] STRAP_ADDR_5 = 7'h36;
	localparam logic [6:0] STRAP_ADDR_6 = 7'h38;
	localparam logic [6:0] STRAP_ADDR_7 = 7'h3c;
	// ==========================================================
	// one register access request
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dmra_req_s;
	// ==========================================================
	// arbiter states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOCAL = 2'b01,
		ST_REMOTE = 2'b10
	} dmra_state_e;
endpackage : dmra_pkg

// [dual_master_register_access_tb.sv]
/* Self-checking bench for dmra_arbiter with a local and a remote master.
   Assumes the register map and strap decode of dmra_pkg. */
`timescale 1ns/100ps
module dual_master_register_access_tb;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, cam = 1'b0, disp = 1'b0;
	logic ce = 1'b1;
	logic [2:0] strap = 3'h0;
	logic l_done, r_done, cam_en, disp_en;
	logic [7:0] l_rd, r_rd, q0, q1;
	logic [6:0] act;
	dmra_pkg::dmra_req_s l_req, r_req;
	int n_mismatch = 0, checked = 0;
	logic [6:0] exp_a [8] = '{7'h2c,7'h2e,7'h30,7'h32,7'h34,7'h36,7'h38,7'h3c};
	always #12.5 i_clk_sys = ~i_clk_sys;
	dmra_arbiter dut (.i_clk_sys, .i_rst, .i_ce(ce), .i_address_strap_pin(strap),
		.i_pt_req_camera(cam), .i_pt_req_display(disp), .i_local_req(l_req),
		.o_local_done(l_done), .o_local_rdata(l_rd), .i_remote_req(r_req),
		.o_remote_done(r_done), .o_remote_rdata(r_rd), .o_active_slave_address(act),
		.o_pt_camera_en(cam_en), .o_pt_display_en(disp_en));
	dmra_master_model u_loc (.i_clk_sys, .i_done(l_done), .i_rdata(l_rd),
		.o_req(l_req));
	dmra_master_model u_rem (.i_clk_sys, .i_done(r_done), .i_rdata(r_rd),
		.o_req(r_req));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tally_and_finish();
		n_mismatch += u_loc.n_late + u_rem.n_late;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	initial begin
		#(25 * 8000);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		for (int s = 0; s < 8; s++) begin
			strap <= 3'(s);
			i_rst <= 1'b1;
			repeat (10) @(posedge i_clk_sys);
			i_rst <= 1'b0;
			repeat (3) @(posedge i_clk_sys);
			chk("active address", {1'b0, exp_a[s]}, {1'b0, act});
			u_loc.access(1'b0, dmra_pkg::ADDR_SLAVE_ADDRESS_SELECT,
				8'h00, q0);
			chk("address register", {exp_a[s], 1'b0}, q0);
		end
		u_loc.access(1'b1, dmra_pkg::ADDR_SLAVE_ADDRESS_SELECT,
			8'hab, q0);
		repeat (3) @(posedge i_clk_sys);
		chk("override address", 8'h55, {1'b0, act});
		u_rem.access(1'b0, dmra_pkg::ADDR_SLAVE_ADDRESS_SELECT,
			8'h00, q0);
		chk("written address", 8'hab, q0);
		fork
			u_loc.access(1'b1, dmra_pkg::ADDR_HANDOVER_MAILBOX_A,
				8'h5a, q0);
			u_rem.access(1'b1, dmra_pkg::ADDR_HANDOVER_MAILBOX_A,
				8'ha5, q1);
		join
		fork
			u_loc.access(1'b0, dmra_pkg::ADDR_HANDOVER_MAILBOX_A,
				8'h00, q0);
			u_rem.access(1'b1, dmra_pkg::ADDR_HANDOVER_MAILBOX_B,
				8'hc3, q1);
		join
		chk("mailbox a", 8'ha5, q0);
		u_loc.access(1'b0, dmra_pkg::ADDR_HANDOVER_MAILBOX_B,
			8'h00, q0);
		chk("mailbox b", 8'hc3, q0);
		u_rem.access(1'b0, dmra_pkg::ADDR_HANDOVER_MAILBOX_A,
			8'h00, q1);
		chk("mailbox a reread", 8'ha5, q1);
		u_loc.access(1'b0, 8'h1a, 8'h00, q0);
		chk("unmapped read", 8'h00, q0);
		cam <= 1'b1;
		disp <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		chk("camera enable", 8'h01, {7'h00, cam_en});
		disp <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		chk("display held off", 8'h00, {7'h00, disp_en});
		cam <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
		chk("display after handover", 8'h01, {7'h00, disp_en});
		ce <= 1'b0;
		disp <= 1'b0;
		repeat (5) @(posedge i_clk_sys);
		chk("display frozen", 8'h01, {7'h00, disp_en});
		ce <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		chk("display released", 8'h00, {7'h00, disp_en});
		tally_and_finish();
	end
endmodule : dual_master_register_access_tb
